//--- otw_overtravel.sv
// overtravel stop sequencing and latched overtravel warning for one axis
// assumes references, power, stop and torque-mode flags come from REF_CLK logic
//
// Overview of operation
// - forward limit off blocks forward travel
// - reverse limit off blocks reverse travel
// - travel away from tripped limit allowed
// - forward limit used or ignored, at restart
// - reverse limit ignored with code 8
// - stop by brake, brake then coast, coast
// - decelerate then zero clamp or coast
// - zero clamp holds position reference zero
// - coast mode removes all drive
// - torque control never decelerates, ends coasting
// - deceleration uses emergency stop torque setting
// - applied torque capped at motor maximum
// - latch warning on overtravel with power
// - warning only when enable digit is 1
// - with reference, warn only same direction
// - without reference, warn either direction
// - no warning while power is off
// - no warning on power turning on
// - alarm clear clears the warning unless a fresh trip comes in the same cycle
// - cleared warning waits for fresh overtravel
// - warning never alters stop or commands
`timescale 1ns/10ps
`default_nettype none
module otw_overtravel
  import otw_pkg::*;
(
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  input  wire logic             FWD_LIMIT_IN,
  input  wire logic             REV_LIMIT_IN,
  input  wire logic [CFG_W-1:0] FWD_LIMIT_CFG,
  input  wire logic [CFG_W-1:0] REV_LIMIT_CFG,
  input  wire logic [CFG_W-1:0] STOP_METHOD_SEL,
  input  wire logic [CFG_W-1:0] WARN_ENABLE_CFG,
  input  wire logic [TQ_W-1:0]  ESTOP_TORQUE_LEVEL,
  input  wire logic [TQ_W-1:0]  MAX_TORQUE_PCT,
  input  wire logic             MOTOR_POWER_ON,
  input  wire logic             TORQUE_CTRL,
  input  wire logic             MOTOR_STOPPED,
  input  wire logic             REF_FWD,
  input  wire logic             REF_REV,
  input  wire logic             ALARM_CLEAR,
  output logic                  FWD_OVERTRAVEL,
  output logic                  REV_OVERTRAVEL,
  output logic                  FWD_REF_PASS,
  output logic                  REV_REF_PASS,
  output logic                  DYNAMIC_BRAKE_STOP,
  output logic                  DECEL_ACTIVE,
  output logic [TQ_W-1:0]       ESTOP_TORQUE,
  output logic                  ZERO_CLAMP,
  output logic                  BASEBLOCK,
  output logic                  WARN_ACTIVE,
  output logic [11:0]           WARN_CODE
);

  // whole module state
  typedef struct packed {
    logic             cfg_loaded;
    logic             fwd_ign;
    logic             rev_ign;
    logic [3:0]       stop_d0;
    logic [3:0]       stop_d1;
    otw_state_t       st;
    logic             pwr_prev;
    logic             otd_prev;
    logic             fwd_ot;
    logic             rev_ot;
    logic             fwd_pass;
    logic             rev_pass;
    logic             db;
    logic             decel;
    logic [TQ_W-1:0]  tq;
    logic             zclamp;
    logic             bblock;
    logic             warn;
    logic [11:0]      code;
  } otw_regs_t;

  otw_regs_t s_r;
  otw_regs_t s_nxt;

  logic [1:0] lim_s;
  logic       fwd_ot_c;
  logic       rev_ot_c;
  logic       trip_c;
  logic       otd_c;
  logic       warn_en_c;
  logic       warn_set_c;
  logic       use_decel_c;
  logic [TQ_W-1:0] tq_cap_c;

  // limit pins into the clock domain
  otw_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk  (REF_CLK),
    .rst  (RST),
    .din  ({REV_LIMIT_IN, FWD_LIMIT_IN}),
    .dout (lim_s)
  );

  // overtravel decode, trip detection and warning conditions
  always_comb
  begin
    fwd_ot_c    = !s_r.fwd_ign && !lim_s[0];
    rev_ot_c    = !s_r.rev_ign && !lim_s[1];
    trip_c      = (fwd_ot_c && REF_FWD) || (rev_ot_c && REF_REV);
    // direction filter for the warning
    if (REF_FWD || REF_REV)
      otd_c = (fwd_ot_c && REF_FWD) || (rev_ot_c && REF_REV);
    else
      otd_c = fwd_ot_c || rev_ot_c;
    warn_en_c   = WARN_ENABLE_CFG[DIG3_LSB +: 4] == WARN_ON;
    // fresh overtravel only, power on now and last cycle
    warn_set_c  = warn_en_c && MOTOR_POWER_ON && s_r.pwr_prev
                  && otd_c && !s_r.otd_prev;
    use_decel_c = !TORQUE_CTRL &&
                  (s_r.stop_d1 == STOP_DEC_CLAMP || s_r.stop_d1 == STOP_DEC_COAST);
    // cap the emergency stop torque at motor maximum
    tq_cap_c    = (ESTOP_TORQUE_LEVEL > MAX_TORQUE_PCT) ?
                  MAX_TORQUE_PCT : ESTOP_TORQUE_LEVEL;
  end

  // next state of the whole module
  always_comb
  begin
    s_nxt = s_r;
    // configuration is captured once after reset release
    if (!s_r.cfg_loaded)
    begin
      s_nxt.cfg_loaded = 1'b1;
      s_nxt.fwd_ign = FWD_LIMIT_CFG[DIG3_LSB +: 4] == LIM_IGNORE;
      s_nxt.rev_ign = REV_LIMIT_CFG[DIG0_LSB +: 4] == LIM_IGNORE;
      s_nxt.stop_d0 = STOP_METHOD_SEL[DIG0_LSB +: 4];
      s_nxt.stop_d1 = STOP_METHOD_SEL[DIG1_LSB +: 4];
    end

    // stop sequencer, driven by trip, power, stopped and torque-mode inputs, never by the warning
    unique case (s_r.st)
      ST_RUN:
      begin
        if (MOTOR_POWER_ON && trip_c)
        begin
          if (use_decel_c)
            s_nxt.st = ST_DECEL;
          else if (s_r.stop_d0 == STOP_COAST)
            s_nxt.st = ST_COAST;
          else
            s_nxt.st = ST_DB;
        end
      end
      ST_DB:
      begin
        if (!MOTOR_POWER_ON || !trip_c)
          s_nxt.st = ST_RUN;
        else if (MOTOR_STOPPED && (s_r.stop_d0 == STOP_DB_COAST || TORQUE_CTRL))
          s_nxt.st = ST_COAST;
      end
      ST_DECEL:
      begin
        if (!MOTOR_POWER_ON || !trip_c)
          s_nxt.st = ST_RUN;
        else if (TORQUE_CTRL)
          s_nxt.st = (s_r.stop_d0 == STOP_COAST) ? ST_COAST : ST_DB;
        else if (MOTOR_STOPPED)
          s_nxt.st = (s_r.stop_d1 == STOP_DEC_CLAMP) ? ST_ZCLAMP : ST_COAST;
      end
      ST_ZCLAMP:
      begin
        if (!MOTOR_POWER_ON || !trip_c)
          s_nxt.st = ST_RUN;
        else if (TORQUE_CTRL)
          s_nxt.st = ST_COAST;
      end
      ST_COAST:
      begin
        if (!MOTOR_POWER_ON || !trip_c)
          s_nxt.st = ST_RUN;
      end
      default:
        s_nxt.st = ST_RUN;
    endcase

    // registered status and reference gating
    s_nxt.fwd_ot   = fwd_ot_c;
    s_nxt.rev_ot   = rev_ot_c;
    s_nxt.fwd_pass = REF_FWD && !fwd_ot_c;
    s_nxt.rev_pass = REF_REV && !rev_ot_c;
    s_nxt.db       = s_nxt.st == ST_DB;
    s_nxt.decel    = s_nxt.st == ST_DECEL;
    s_nxt.tq       = (s_nxt.st == ST_DECEL) ? tq_cap_c : ESTOP_TQ_RST;
    s_nxt.zclamp   = s_nxt.st == ST_ZCLAMP;
    s_nxt.bblock   = s_nxt.st == ST_COAST;

    // warning latch, a fresh trip wins over a clear
    s_nxt.pwr_prev = MOTOR_POWER_ON;
    s_nxt.otd_prev = otd_c;
    if (warn_set_c)
      s_nxt.warn = 1'b1;
    else if (ALARM_CLEAR)
      s_nxt.warn = 1'b0;
    s_nxt.code     = s_nxt.warn ? LIMIT_WARNING_CODE : NO_WARNING_CODE;
  end

  // state register
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s_r <= '{cfg_loaded: 1'b0, fwd_ign: 1'b0, rev_ign: 1'b0,
               stop_d0: STOP_D0_RST, stop_d1: STOP_D1_RST, st: ST_RUN,
               pwr_prev: 1'b0, otd_prev: 1'b0, fwd_ot: 1'b0, rev_ot: 1'b0,
               fwd_pass: 1'b0, rev_pass: 1'b0, db: 1'b0, decel: 1'b0,
               tq: ESTOP_TQ_RST, zclamp: 1'b0, bblock: 1'b0, warn: 1'b0, code: NO_WARNING_CODE};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign FWD_OVERTRAVEL     = s_r.fwd_ot;
  assign REV_OVERTRAVEL     = s_r.rev_ot;
  assign FWD_REF_PASS       = s_r.fwd_pass;
  assign REV_REF_PASS       = s_r.rev_pass;
  assign DYNAMIC_BRAKE_STOP = s_r.db;
  assign DECEL_ACTIVE       = s_r.decel;
  assign ESTOP_TORQUE       = s_r.tq;
  assign ZERO_CLAMP         = s_r.zclamp;
  assign BASEBLOCK          = s_r.bblock;
  assign WARN_ACTIVE        = s_r.warn;
  assign WARN_CODE          = s_r.code;

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_fresh_trip;
    warn_set_c;
  endsequence

  sequence s_clear_only;
    ALARM_CLEAR && !warn_set_c;
  endsequence

  property p_warn_raise;
    s_fresh_trip |=> WARN_ACTIVE && WARN_CODE == LIMIT_WARNING_CODE;
  endproperty

  property p_warn_clear;
    s_clear_only |=> !WARN_ACTIVE;
  endproperty

  a_fwd_block: assert property (FWD_OVERTRAVEL |-> !FWD_REF_PASS)
    else $error("forward reference passed during forward overtravel");
  a_rev_block: assert property (REV_OVERTRAVEL |-> !REV_REF_PASS)
    else $error("reverse reference passed during reverse overtravel");
  a_away_pass: assert property (REF_REV && !rev_ot_c && fwd_ot_c |=> REV_REF_PASS)
    else $error("reverse reference blocked by forward limit");
  a_fwd_ignore: assert property (s_r.cfg_loaded && s_r.fwd_ign |=> !FWD_OVERTRAVEL)
    else $error("ignored forward limit reported overtravel");
  a_tq_cap: assert property (##1 DECEL_ACTIVE |->
                             ESTOP_TORQUE <= $past(MAX_TORQUE_PCT) && ESTOP_TORQUE <= $past(ESTOP_TORQUE_LEVEL))
    else $error("stop torque above limit");
  a_trq_nodecel: assert property (TORQUE_CTRL |=> !DECEL_ACTIVE)
    else $error("deceleration under torque control");
  a_warn_raise: assert property (p_warn_raise)
    else $error("fresh overtravel not latched");
  a_warn_clear: assert property (p_warn_clear)
    else $error("alarm clear did not clear warning");
  a_pwr_off: assert property (!MOTOR_POWER_ON |=> !$rose(WARN_ACTIVE))
    else $error("warning raised with power off");
  a_pwr_rise: assert property ($rose(MOTOR_POWER_ON) |=> !$rose(WARN_ACTIVE))
    else $error("warning raised on power up");
  a_dir_filter: assert property (REF_FWD && !REF_REV && !fwd_ot_c |-> !warn_set_c)
    else $error("warning for opposite limit");
  a_no_rearm: assert property (s_r.otd_prev && otd_c |-> !warn_set_c)
    else $error("warning re-raised without fresh overtravel");
  a_clamp_stop: assert property (ZERO_CLAMP |-> !BASEBLOCK && ESTOP_TORQUE == ESTOP_TQ_RST)
    else $error("zero clamp mixed with coast or decel");

  // stop sequencer outcomes and reverse limit ignore
  a_tq_idle: assert property (!DECEL_ACTIVE |-> ESTOP_TORQUE == ESTOP_TQ_RST)
    else $error("stop torque applied outside deceleration");
  a_coast_only: assert property (BASEBLOCK |-> !DYNAMIC_BRAKE_STOP && !DECEL_ACTIVE && !ZERO_CLAMP)
    else $error("drive applied in coast state");
  a_db_hold: assert property (DYNAMIC_BRAKE_STOP && s_r.stop_d0 == STOP_DB_HOLD && !TORQUE_CTRL &&
                              MOTOR_POWER_ON && trip_c |=> DYNAMIC_BRAKE_STOP)
    else $error("brake stop released while overtravel persists");
  a_trq_coast: assert property (DYNAMIC_BRAKE_STOP && TORQUE_CTRL && MOTOR_STOPPED &&
                                MOTOR_POWER_ON && trip_c |=> BASEBLOCK)
    else $error("torque control stop did not end coasting");
  a_rev_ignore: assert property (s_r.cfg_loaded && s_r.rev_ign |=> !REV_OVERTRAVEL)
    else $error("ignored reverse limit reported overtravel");

  // warning code and enable
  a_code_match: assert property (WARN_CODE == (WARN_ACTIVE ? LIMIT_WARNING_CODE : NO_WARNING_CODE))
    else $error("warning code disagrees with warning flag");
  a_warn_gate: assert property (WARN_ENABLE_CFG[DIG3_LSB +: 4] != WARN_ON && !WARN_ACTIVE |=> !WARN_ACTIVE)
    else $error("warning raised while detection disabled");

endmodule
`default_nettype wire

//--- otw_partner.sv
// far side model: normally closed limit switches and host clear line
// assumes bench commands change just after REF_CLK rising edges
`timescale 1ns/10ps
`default_nettype none
module otw_partner (
  input  wire logic clk,
  input  wire logic fwd_open,
  input  wire logic rev_open,
  input  wire logic clr_req,
  output logic      fwd_pin,
  output logic      rev_pin,
  output logic      alarm_clear
);
  // open contact or broken wire reads low, so it looks like overtravel
  always_ff @(posedge clk)
  begin
    fwd_pin     <= !fwd_open;
    rev_pin     <= !rev_open;
    alarm_clear <= clr_req;
  end
endmodule
`default_nettype wire

//--- otw_pkg.sv
// overtravel stop and warning: shared constants, config codes and states
// assumes all configuration digits arrive as 4-bit BCD-style fields
package otw_pkg;

  // widths
  localparam int TQ_W  = 10;
  localparam int CFG_W = 16;

  // digit positions inside the 16-bit configuration words
  localparam int DIG0_LSB = 0;
  localparam int DIG1_LSB = 4;
  localparam int DIG3_LSB = 12;

  // limit configuration digit codes
  localparam logic [3:0] LIM_USE    = 4'h1;
  localparam logic [3:0] LIM_IGNORE = 4'h8;

  // stop method, first digit
  localparam logic [3:0] STOP_DB_HOLD  = 4'h0;
  localparam logic [3:0] STOP_DB_COAST = 4'h1;
  localparam logic [3:0] STOP_COAST    = 4'h2;

  // stop method, second digit
  localparam logic [3:0] STOP_DEC_CLAMP = 4'h1;
  localparam logic [3:0] STOP_DEC_COAST = 4'h2;

  // warning enable digit code
  localparam logic [3:0] WARN_ON = 4'h1;

  // reset values of latched configuration
  localparam logic [3:0] STOP_D0_RST = 4'h0;
  localparam logic [3:0] STOP_D1_RST = 4'h0;

  // emergency stop torque, percent of rated
  localparam logic [TQ_W-1:0] ESTOP_TQ_MAX = 10'h320;
  localparam logic [TQ_W-1:0] ESTOP_TQ_RST = 10'h000;

  // code presented with the latched overtravel warning
  localparam logic [11:0] LIMIT_WARNING_CODE = 12'h9a0;
  localparam logic [11:0] NO_WARNING_CODE    = 12'h000;

  // stop sequencer states, gray along run, decel, clamp, coast
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_DECEL  = 3'b001,
    ST_ZCLAMP = 3'b011,
    ST_COAST  = 3'b010,
    ST_DB     = 3'b100
  } otw_state_t;

endpackage

//--- otw_sync.sv
// two-flop synchroniser for the limit switch pins
// assumes pins are asynchronous to REF_CLK; reset value reads as tripped
`timescale 1ns/10ps
`default_nettype none
module otw_sync
  import otw_pkg::*;
#(
  parameter int WIDTH = 2
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // one pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_r;
      logic stab_r;
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end
        else
        begin
          meta_r <= din[i];
          stab_r <= meta_r;
        end
      end
      assign dout[i] = stab_r;
    end
  endgenerate

endmodule
`default_nettype wire

//--- tb_overtravel_stop_and_warning.sv
// self-checking bench for the overtravel stop and warning block
// assumes otw_pkg, otw_overtravel and otw_partner are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_overtravel_stop_and_warning;
  import otw_pkg::*;
  logic             clk = 0, rst = 1, fo = 0, ro = 0, cr = 0;
  logic             pwr = 0, tqc = 0, stp = 0, rf = 0, rr = 0;
  logic [CFG_W-1:0] fcfg = 16'h1000, rcfg = 16'h0001, scfg = 16'h0010, wcfg = 16'h1000;
  logic [TQ_W-1:0]  lvl = 10'h320, mx = 10'h12c, tq;
  logic             fpin, rpin, clr, fot, rot, fps, rps, db, dec, zc, bb, wa;
  logic [11:0]      wc;
  logic [15:0]      e;
  int               fail_count = 0, total_checks = 0;
  // packing: stop code, torque mode, running db dec bb, stopped db dec bb zc
  logic [15:0]      stops [5] = '{16'h0048, 16'h0142, 16'h0212, 16'h2022, 16'h11c2};

  otw_partner u_partner (.clk(clk), .fwd_open(fo), .rev_open(ro), .clr_req(cr),
    .fwd_pin(fpin), .rev_pin(rpin), .alarm_clear(clr));
  otw_overtravel dut (.REF_CLK(clk), .RST(rst), .FWD_LIMIT_IN(fpin), .REV_LIMIT_IN(rpin),
    .FWD_LIMIT_CFG(fcfg), .REV_LIMIT_CFG(rcfg), .STOP_METHOD_SEL(scfg), .WARN_ENABLE_CFG(wcfg),
    .ESTOP_TORQUE_LEVEL(lvl), .MAX_TORQUE_PCT(mx), .MOTOR_POWER_ON(pwr), .TORQUE_CTRL(tqc),
    .MOTOR_STOPPED(stp), .REF_FWD(rf), .REF_REV(rr), .ALARM_CLEAR(clr),
    .FWD_OVERTRAVEL(fot), .REV_OVERTRAVEL(rot), .FWD_REF_PASS(fps), .REV_REF_PASS(rps),
    .DYNAMIC_BRAKE_STOP(db), .DECEL_ACTIVE(dec), .ESTOP_TORQUE(tq), .ZERO_CLAMP(zc),
    .BASEBLOCK(bb), .WARN_ACTIVE(wa), .WARN_CODE(wc));

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  // wait n edges, then step past the edge so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [11:0] x, input logic [11:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // restart with new configuration, everything idle except the reverse reference
  task automatic reboot(input logic [CFG_W-1:0] f, input logic [CFG_W-1:0] r, input logic [CFG_W-1:0] s);
    @(posedge clk);
    rst <= 1;
    fcfg <= f;
    rcfg <= r;
    scfg <= s;
    pwr <= 0;
    tqc <= 0;
    stp <= 0;
    rf <= 0;
    fo <= 0;
    ro <= 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    wt(4);
  endtask

  // one-cycle alarm clear from the host
  task automatic clear_pulse;
    @(posedge clk);
    cr <= 1;
    @(posedge clk);
    cr <= 0;
    wt(4);
  endtask

  // main sequence
  initial
  begin
    reboot(16'h1000, 16'h0001, 16'h0010);
    @(posedge clk);
    rf <= 1;
    wt(2);
    chk("fwd_pass", 1, fps);
    @(posedge clk);
    pwr <= 1;
    fo <= 1;
    wt(2);
    chk("fwd_ot_early", 0, fot);
    wt(4);
    chk("fwd_ot", 1, fot);
    chk("fwd_pass", 0, fps);
    chk("decel", 1, dec);
    chk("estop_tq", mx, tq);
    chk("warn", 1, wa);
    chk("code", LIMIT_WARNING_CODE, wc);
    @(posedge clk);
    rr <= 1;
    fcfg <= 16'h8000;
    wt(2);
    chk("rev_pass", 1, rps);
    chk("fwd_ot_kept", 1, fot);
    @(posedge clk);
    rr <= 0;
    stp <= 1;
    wt(2);
    chk("zclamp", 1, zc);
    chk("decel_end", 0, dec);
    chk("tq_end", 0, tq);
    clear_pulse();
    chk("warn_clr", 0, wa);
    chk("zclamp_kept", 1, zc);
    @(posedge clk);
    fo <= 0;
    stp <= 0;
    wt(5);
    chk("fwd_ot", 0, fot);
    @(posedge clk);
    fo <= 1;
    @(posedge clk);
    fo <= 0;
    wt(5);
    chk("warn_blip", 1, wa);
    clear_pulse();
    @(posedge clk);
    pwr <= 0;
    rf <= 0;
    ro <= 1;
    rr <= 1;
    wt(5);
    chk("rev_ot", 1, rot);
    chk("rev_pass", 0, rps);
    chk("warn_off", 0, wa);
    @(posedge clk);
    pwr <= 1;
    wt(5);
    chk("warn_pwrup", 0, wa);
    @(posedge clk);
    ro <= 0;
    rr <= 0;
    rf <= 1;
    wt(5);
    @(posedge clk);
    ro <= 1;
    wt(5);
    chk("warn_opp", 0, wa);
    @(posedge clk);
    ro <= 0;
    wt(5);
    @(posedge clk);
    rf <= 0;
    ro <= 1;
    wt(5);
    chk("warn_noref", 1, wa);
    @(posedge clk);
    wcfg <= 16'h0000;
    clear_pulse();
    @(posedge clk);
    ro <= 0;
    wt(5);
    @(posedge clk);
    ro <= 1;
    wt(5);
    chk("warn_dis", 0, wa);
    foreach (stops[i])
    begin
      e = stops[i];
      reboot(16'h1000, 16'h0001, {8'h00, e[15:8]});
      @(posedge clk);
      tqc <= e[7];
      lvl <= 10'h064;
      pwr <= 1;
      rf <= 1;
      fo <= 1;
      wt(6);
      chk("db_run", e[6], db);
      chk("dec_run", e[5], dec);
      chk("bb_run", e[4], bb);
      chk("tq_run", e[5] ? lvl : '0, tq);
      @(posedge clk);
      stp <= 1;
      wt(3);
      chk("stopped", e[3:0], {db, dec, bb, zc});
    end
    reboot(16'h8000, 16'h0008, 16'h0010);
    @(posedge clk);
    pwr <= 1;
    rf <= 1;
    rr <= 1;
    fo <= 1;
    ro <= 1;
    wt(6);
    chk("fwd_ign", 0, fot);
    chk("fwd_ign_pass", 1, fps);
    chk("rev_ign", 0, rot);
    chk("rev_ign_pass", 1, rps);
    complete_run();
  end

  // watchdog well beyond the expected run of about 260 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
